// ---- hdl/pcsr_map.svh ----
/*
 Register offsets, field positions, reset codes and sizes of the pad
 configuration and signal routing block.
 Assumes byte addresses on a 12-bit APB address, one 32-bit word per register.
*/
`ifndef PCSR_MAP_SVH
`define PCSR_MAP_SVH

`define PCSR_NPADS        22
`define PCSR_NPI          8
`define PCSR_NPO          8
`define PCSR_SEL_W        5
`define PCSR_RSEL_W       3
`define PCSR_CFG_W        9
`define PCSR_ADDR_W       12

// register byte offsets
`define PCSR_OFF_DOUT     12'h000
`define PCSR_OFF_OE       12'h004
`define PCSR_OFF_IN       12'h008
`define PCSR_OFF_ISTAT    12'h00c
`define PCSR_OFF_IMASK    12'h010
`define PCSR_OFF_ITYPE    12'h014
`define PCSR_OFF_IPOL     12'h018
`define PCSR_OFF_HOLD     12'h01c
`define PCSR_OFF_CFG0     12'h040
`define PCSR_OFF_ISEL0    12'h100

// pad config word fields
`define PCSR_CF_FUNC_LO   0
`define PCSR_CF_FUNC_HI   1
`define PCSR_CF_IE        2
`define PCSR_CF_WPU       3
`define PCSR_CF_WPD       4
`define PCSR_CF_REN       5
`define PCSR_CF_RSEL_LO   6
`define PCSR_CF_RSEL_HI   8

// function selector codes
`define PCSR_FN_FIX0      2'h0
`define PCSR_FN_GPIO      2'h1
`define PCSR_FN_FIX2      2'h2

// reset configuration codes; 5 stands for 1*, 6 for 0*
`define PCSR_RC_0         3'h0
`define PCSR_RC_1         3'h1
`define PCSR_RC_2         3'h2
`define PCSR_RC_3         3'h3
`define PCSR_RC_4         3'h4
`define PCSR_RC_1S        3'h5
`define PCSR_RC_0S        3'h6

// per-pad reset codes, pad 21 leftmost
`define PCSR_RESET_TABLE  {`PCSR_RC_4, `PCSR_RC_3, `PCSR_RC_0S, `PCSR_RC_0, \
                           `PCSR_RC_3, `PCSR_RC_3, `PCSR_RC_3, `PCSR_RC_3, \
                           `PCSR_RC_3, `PCSR_RC_3, `PCSR_RC_0, `PCSR_RC_1, \
                           `PCSR_RC_3, `PCSR_RC_1, `PCSR_RC_1, `PCSR_RC_1S, \
                           `PCSR_RC_1, `PCSR_RC_1, `PCSR_RC_1, `PCSR_RC_1, \
                           `PCSR_RC_0, `PCSR_RC_0}

// the two usb pads
`define PCSR_USB_DM_PAD   18
`define PCSR_USB_DP_PAD   19

`endif

// ---- hdl/pcsr_pkg.sv ----
/*
 Types of the pad configuration and signal routing block.
 Assumes pcsr_map.svh is on the include path.
*/
`include "pcsr_map.svh"

package pcsr_pkg;

   typedef logic [`PCSR_NPADS-1:0]                  pcsr_pads_type;
   typedef logic [`PCSR_CFG_W-1:0]                  pcsr_cfg_type;
   typedef logic [`PCSR_NPADS-1:0][`PCSR_CFG_W-1:0] pcsr_cfg_arr_type;
   typedef logic [`PCSR_NPI-1:0][`PCSR_SEL_W-1:0]   pcsr_isel_arr_type;
   typedef logic [`PCSR_NPI-1:0]                    pcsr_pi_type;
   typedef logic [`PCSR_NPO-1:0]                    pcsr_po_type;
   typedef logic [`PCSR_ADDR_W-1:0]                 pcsr_addr_type;

endpackage

// ---- hdl/pcsr_sync.sv ----
/*
 Three-stage synchroniser for a vector of pad inputs with agreement filter.
 Assumes asynchronous inputs; output rises once stages two and three are both high, falls as soon as they differ.
*/
`timescale 1ns/100ps

module pcsr_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } pcsr_sync_st_type;

   pcsr_sync_st_type s_r;
   pcsr_sync_st_type s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (ce) begin
         s_nxt.s1 = d;
         s_nxt.s2 = s_r.s1;
         s_nxt.s3 = s_r.s2;
         // a bit sets when stages two and three are both high, clears when they differ, holds when both low
         s_nxt.q  = (s_r.q & ~(s_r.s2 ^ s_r.s3)) | (s_r.s2 & s_r.s3);
      end
      if (rst) begin
         s_nxt = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      s_r <= s_nxt;
   end

   assign q = s_r.q;

endmodule

// ---- hdl/pcsr_top.sv ----
/*
 Pad configuration and signal routing for 22 general-purpose pads: function
 selection, buffer enables, pulls, hold, readback, pad interrupts and routing
 of peripheral signals to and from any pad, behind an APB slave.
 Assumes pads, fixed functions, peripherals and the usb controller are outside;
 pad_in is asynchronous, all other inputs are on clk_sys.
 // Function
 // - twenty-two pads, each function chosen by configuration registers
 // - each pad selects pull-up, pull-down, or neither (high impedance)
 // - input pad level is readable by software through a register
 // - each input pad can interrupt on an edge or a level
 // - pads bidirectional, non-inverting, separate buffers, enable tristates driver
 // - hold freezes a pad's present configuration and output level
 // - any peripheral input from any pad, any output onto any pad
 // - direct selector among three fixed functions, index one is plain pad use
 // - reset code 0 input off high impedance; code 1 input on high impedance
 // - reset code 2 enables input buffer and weak pull-down
 // - reset code 3 enables input buffer and weak pull-up
 // - reset code 4 enables output driver and weak pull-up
 // - code 0* input off, own pull-up clear, usb pull-up keeps pad high
 // - code 1* input on, pull-up only when debug-pad fuse clear
 // - after reset every pad takes its code from the reset table
 // - usb pad pull-up is own pull-up OR usb controller pull-up
 // - usb pull-up request comes from a dedicated controller bit
*/
`timescale 1ns/100ps

module pcsr_top
   import pcsr_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire logic                   ce,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire pcsr_pkg::pcsr_addr_type paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire pcsr_pkg::pcsr_pads_type pad_in,
   output pcsr_pkg::pcsr_pads_type      pad_out,
   output pcsr_pkg::pcsr_pads_type      pad_oe,
   output pcsr_pkg::pcsr_pads_type      pad_ie,
   output pcsr_pkg::pcsr_pads_type      pad_pu,
   output pcsr_pkg::pcsr_pads_type      pad_pd,
   input  wire pcsr_pkg::pcsr_pads_type fn0_out,
   input  wire pcsr_pkg::pcsr_pads_type fn0_oe,
   input  wire pcsr_pkg::pcsr_pads_type fn2_out,
   input  wire pcsr_pkg::pcsr_pads_type fn2_oe,
   output pcsr_pkg::pcsr_pads_type      fix_in,
   input  wire pcsr_pkg::pcsr_po_type   peri_out,
   input  wire pcsr_pkg::pcsr_po_type   peri_oe,
   output pcsr_pkg::pcsr_pi_type        peri_in,
   input  wire logic                   usb_dplus_pullup_ctl,
   input  wire logic                   fuse_debug_pads_off,
   output logic                        irq
);

   import pcsr_pkg::*;

   typedef struct packed {
      pcsr_pads_type     dout;
      pcsr_pads_type     gen_oe;
      pcsr_pads_type     istat;
      pcsr_pads_type     imask;
      pcsr_pads_type     itype;
      pcsr_pads_type     ipol;
      pcsr_pads_type     hold;
      pcsr_pads_type     prev;
      pcsr_cfg_arr_type  cfg;
      pcsr_isel_arr_type isel;
      pcsr_pads_type     p_out;
      pcsr_pads_type     p_oe;
      pcsr_pads_type     p_ie;
      pcsr_pads_type     p_pu;
      pcsr_pads_type     p_pd;
      pcsr_pads_type     fin;
      pcsr_pi_type       pin;
      logic [31:0]       rdata;
      logic              ready;
      logic              err;
      logic              irq;
   } pcsr_st_type;

   pcsr_st_type   s_r;
   pcsr_st_type   s_nxt;
   pcsr_pads_type sync_q;

   localparam logic [3*`PCSR_NPADS-1:0] RST_TABLE = `PCSR_RESET_TABLE;

   // config word for a reset code; function one always selected
   function automatic pcsr_cfg_type cfg_from_code(input logic [2:0] code,
                                                  input logic fuse);
      pcsr_cfg_type c;
      c = '0;
      c[`PCSR_CF_FUNC_HI:`PCSR_CF_FUNC_LO] = `PCSR_FN_GPIO;
      case (code)
         `PCSR_RC_0: begin
            c[`PCSR_CF_IE] = 1'b0;
         end
         `PCSR_RC_1: begin
            c[`PCSR_CF_IE] = 1'b1;
         end
         `PCSR_RC_2: begin
            c[`PCSR_CF_IE]  = 1'b1;
            c[`PCSR_CF_WPD] = 1'b1;
         end
         `PCSR_RC_3: begin
            c[`PCSR_CF_IE]  = 1'b1;
            c[`PCSR_CF_WPU] = 1'b1;
         end
         `PCSR_RC_4: begin
            c[`PCSR_CF_WPU] = 1'b1;
         end
         `PCSR_RC_1S: begin
            c[`PCSR_CF_IE]  = 1'b1;
            c[`PCSR_CF_WPU] = ~fuse;
         end
         `PCSR_RC_0S: begin
            c[`PCSR_CF_WPU] = 1'b0;
         end
         default: begin
            c[`PCSR_CF_IE] = 1'b0;
         end
      endcase
      return c;
   endfunction

   // index of a register array slot, or all ones when outside the array
   function automatic int slot(input pcsr_addr_type a, input pcsr_addr_type base,
                               input int n);
      pcsr_addr_type d;
      d = a - base;
      if (a >= base && a[1:0] == 2'h0 && int'(d[`PCSR_ADDR_W-1:2]) < n) begin
         return int'(d[`PCSR_ADDR_W-1:2]);
      end
      return -1;
   endfunction

   pcsr_sync #(
      .W (`PCSR_NPADS)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .d       (pad_in),
      .q       (sync_q)
   );

   always_comb begin
      logic          acc;
      logic          wr;
      logic          hit;
      logic [31:0]   rd;
      pcsr_pads_type clr;
      pcsr_pads_type ev;
      pcsr_pads_type wdat;
      logic [1:0]    fn;
      logic [2:0]    rsel;
      logic [2:0]    code;
      logic [`PCSR_SEL_W-1:0] isel;
      int            cs;
      int            is;
      acc  = psel & penable;
      wr   = 1'b0;
      hit  = 1'b0;
      rd   = '0;
      clr  = '0;
      ev   = '0;
      wdat = pwdata[`PCSR_NPADS-1:0];
      fn   = '0;
      rsel = '0;
      code = '0;
      isel = '0;
      cs   = slot(paddr, `PCSR_OFF_CFG0, `PCSR_NPADS);
      is   = slot(paddr, `PCSR_OFF_ISEL0, `PCSR_NPI);
      s_nxt = s_r;
      if (ce) begin
         // read decode, done one cycle ahead of the completing edge
         hit = 1'b1;
         case (paddr)
            `PCSR_OFF_DOUT:  rd[`PCSR_NPADS-1:0] = s_r.dout;
            `PCSR_OFF_OE:    rd[`PCSR_NPADS-1:0] = s_r.gen_oe;
            `PCSR_OFF_IN:    rd[`PCSR_NPADS-1:0] = s_r.fin & s_r.p_ie;
            `PCSR_OFF_ISTAT: rd[`PCSR_NPADS-1:0] = s_r.istat;
            `PCSR_OFF_IMASK: rd[`PCSR_NPADS-1:0] = s_r.imask;
            `PCSR_OFF_ITYPE: rd[`PCSR_NPADS-1:0] = s_r.itype;
            `PCSR_OFF_IPOL:  rd[`PCSR_NPADS-1:0] = s_r.ipol;
            `PCSR_OFF_HOLD:  rd[`PCSR_NPADS-1:0] = s_r.hold;
            default: begin
               if (cs >= 0) begin
                  rd[`PCSR_CFG_W-1:0] = s_r.cfg[cs];
               end else if (is >= 0) begin
                  rd[`PCSR_SEL_W-1:0] = s_r.isel[is];
               end else begin
                  hit = 1'b0;
               end
            end
         endcase
         // one wait state: answer prepared, then completed on the next edge
         if (acc && !s_r.ready) begin
            s_nxt.ready = 1'b1;
            s_nxt.rdata = hit ? rd : '0;
            s_nxt.err   = ~hit;
         end else begin
            s_nxt.ready = 1'b0;
            s_nxt.err   = 1'b0;
         end
         wr = acc & s_r.ready & pwrite & ~s_r.err;
         if (wr) begin
            case (paddr)
               `PCSR_OFF_DOUT:  s_nxt.dout   = wdat;
               `PCSR_OFF_OE:    s_nxt.gen_oe = wdat;
               `PCSR_OFF_ISTAT: clr          = wdat;
               `PCSR_OFF_IMASK: s_nxt.imask  = wdat;
               `PCSR_OFF_ITYPE: s_nxt.itype  = wdat;
               `PCSR_OFF_IPOL:  s_nxt.ipol   = wdat;
               `PCSR_OFF_HOLD:  s_nxt.hold   = wdat;
               default: begin
                  if (cs >= 0) begin
                     s_nxt.cfg[cs] = pwdata[`PCSR_CFG_W-1:0];
                  end else if (is >= 0) begin
                     s_nxt.isel[is] = pwdata[`PCSR_SEL_W-1:0];
                  end
               end
            endcase
         end

         s_nxt.fin  = sync_q;
         s_nxt.prev = s_r.fin;
         for (int i = 0; i < `PCSR_NPADS; i++) begin
            // itype 1 = level, ipol 1 = high level or rising edge
            if (s_r.itype[i]) begin
               ev[i] = s_r.cfg[i][`PCSR_CF_IE] & (s_r.fin[i] == s_r.ipol[i]);
            end else begin
               ev[i] = s_r.cfg[i][`PCSR_CF_IE] & (s_r.fin[i] ^ s_r.prev[i])
                       & (s_r.fin[i] == s_r.ipol[i]);
            end
            // held pads keep every pad-facing output as it stands
            if (!s_r.hold[i]) begin
               fn   = s_r.cfg[i][`PCSR_CF_FUNC_HI:`PCSR_CF_FUNC_LO];
               rsel = s_r.cfg[i][`PCSR_CF_RSEL_HI:`PCSR_CF_RSEL_LO];
               case (fn)
                  `PCSR_FN_FIX0: begin
                     s_nxt.p_out[i] = fn0_out[i];
                     s_nxt.p_oe[i]  = fn0_oe[i];
                  end
                  `PCSR_FN_GPIO: begin
                     if (s_r.cfg[i][`PCSR_CF_REN]) begin
                        s_nxt.p_out[i] = peri_out[rsel];
                        s_nxt.p_oe[i]  = peri_oe[rsel];
                     end else begin
                        s_nxt.p_out[i] = s_r.dout[i];
                        s_nxt.p_oe[i]  = s_r.gen_oe[i];
                     end
                  end
                  `PCSR_FN_FIX2: begin
                     s_nxt.p_out[i] = fn2_out[i];
                     s_nxt.p_oe[i]  = fn2_oe[i];
                  end
                  default: begin
                     s_nxt.p_out[i] = 1'b0;
                     s_nxt.p_oe[i]  = 1'b0;
                  end
               endcase
               s_nxt.p_ie[i] = s_r.cfg[i][`PCSR_CF_IE];
               s_nxt.p_pd[i] = s_r.cfg[i][`PCSR_CF_WPD];
               s_nxt.p_pu[i] = s_r.cfg[i][`PCSR_CF_WPU];
               if (i == `PCSR_USB_DM_PAD || i == `PCSR_USB_DP_PAD) begin
                  s_nxt.p_pu[i] = s_r.cfg[i][`PCSR_CF_WPU]
                                  | usb_dplus_pullup_ctl;
               end
            end
         end
         // peripheral inputs from any pad; out-of-range selection reads low
         for (int k = 0; k < `PCSR_NPI; k++) begin
            isel = s_r.isel[k];
            s_nxt.pin[k] = (int'(isel) < `PCSR_NPADS) ? s_r.fin[isel] : 1'b0;
         end
         // new events win over a clear in the same cycle
         s_nxt.istat = (s_r.istat & ~clr) | ev;
         s_nxt.irq   = |(s_nxt.istat & s_r.imask);
      end
      if (rst) begin
         s_nxt = '0;
         for (int i = 0; i < `PCSR_NPADS; i++) begin
            code = RST_TABLE[3*i +: 3];
            s_nxt.cfg[i]    = cfg_from_code(code, fuse_debug_pads_off);
            s_nxt.gen_oe[i] = (code == `PCSR_RC_4);
            s_nxt.isel      = '1;
         end
         // pad outputs settle from the config on the first enabled cycle
      end
   end

   always_ff @(posedge clk_sys) begin
      s_r <= s_nxt;
   end

   assign prdata  = s_r.rdata;
   assign pready  = s_r.ready;
   assign pslverr = s_r.err;
   assign pad_out = s_r.p_out;
   assign pad_oe  = s_r.p_oe;
   assign pad_ie  = s_r.p_ie;
   assign pad_pu  = s_r.p_pu;
   assign pad_pd  = s_r.p_pd;
   assign fix_in  = s_r.fin;
   assign peri_in = s_r.pin;
   assign irq     = s_r.irq;

endmodule

// ---- tb/pcsr_checker.sv ----
/*
 Port-level assertions for the pad configuration and routing block.
 Assumes it is bound to pcsr_top and that ce is held high throughout.
*/
`timescale 1ns/100ps

module pcsr_checker
   import pcsr_pkg::*;
(
   input wire logic                    clk_sys,
   input wire logic                    rst,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire pcsr_pkg::pcsr_pads_type pad_in,
   input wire pcsr_pkg::pcsr_pads_type pad_ie,
   input wire pcsr_pkg::pcsr_pads_type pad_pu,
   input wire pcsr_pkg::pcsr_pads_type fix_in,
   input wire logic                    usb_dplus_pullup_ctl,
   input wire logic                    irq
);
   // pad outputs settle from reset values on the first edge after release
   logic [1:0] age_r;
   logic [1:0] age_nxt;

   always_comb begin
      age_nxt = (age_r == 2'h3) ? age_r : age_r + 2'h1;
   end

   always_ff @(posedge clk_sys) begin
      age_r <= rst ? 2'h0 : age_nxt;
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready not one cycle after access");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_data_held: assert property (!pready |-> $stable(prdata))
      else $error("prdata moved outside an answer");
   a_usb_pull_or: assert property (usb_dplus_pullup_ctl [*3] |-> pad_pu[18] && pad_pu[19])
      else $error("usb pull-up request not on both usb pads");
   a_sync_follow: assert property ($stable(pad_in) [*6] |-> fix_in == pad_in)
      else $error("synchronised pad level does not follow pad");
   a_ie_by_write: assert property (age_r == 2'h3 && $changed(pad_ie)
      |-> $past(pready && pwrite, 2))
      else $error("input enable changed without a register write");

   cover property (pslverr);
   cover property (irq);
   cover property ($rose(pad_pu[18]));
endmodule

bind pcsr_top pcsr_checker chk_i (
   .clk_sys, .rst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .pad_in,
   .pad_ie, .pad_pu, .fix_in, .usb_dplus_pullup_ctl, .irq
);

// ---- tb/pad_config_and_signal_routing_bench.sv ----
/*
 Self-checking bench for the pad configuration and routing block.
 Assumes pcsr_pkg and pcsr_map.svh are compiled first; ce is held high.
*/
`timescale 1ns/100ps
`include "pcsr_map.svh"

module pad_config_and_signal_routing_bench;
   import pcsr_pkg::*;
   logic                         clk_sys, rst, ce, psel, penable, pwrite, pready, pslverr;
   logic                         irq, err, usb_dplus_pullup_ctl, fuse_debug_pads_off;
   pcsr_addr_type                paddr;
   logic [31:0]                  pwdata, prdata, rd;
   pcsr_pads_type                pad_in, pad_out, pad_oe, pad_ie, pad_pu, pad_pd, fix_in;
   pcsr_pads_type                fn0_out, fn0_oe, fn2_out, fn2_oe;
   pcsr_po_type                  peri_out, peri_oe;
   pcsr_pi_type                  peri_in;
   int                           fails, check_count;
   localparam logic [21:0][2:0]  CODES = `PCSR_RESET_TABLE;

   pcsr_top uut (
      .clk_sys, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .pad_in, .pad_out, .pad_oe, .pad_ie, .pad_pu, .pad_pd, .fn0_out, .fn0_oe,
      .fn2_out, .fn2_oe, .fix_in, .peri_out, .peri_oe, .peri_in, .usb_dplus_pullup_ctl,
      .fuse_debug_pads_off, .irq
   );

   always #50 clk_sys = ~clk_sys;

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic w, input pcsr_addr_type a, input logic [31:0] d);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input pcsr_addr_type a, input logic [31:0] d);
      apb(1'b1, a, d);
      repeat (2) @(posedge clk_sys);
   endtask

   function automatic pcsr_addr_type cfg(input int n);
      return `PCSR_OFF_CFG0 + 12'(4 * n);
   endfunction

   // expected pad levels per reset code; k picks ie, pu, pd or oe
   function automatic pcsr_pads_type rv(input int k, input logic f);
      pcsr_pads_type v;
      logic [2:0]    c;
      v = '0;
      for (int i = 0; i < 22; i++) begin
         c = CODES[i];
         case (k)
            0: v[i] = c inside {`PCSR_RC_1, `PCSR_RC_2, `PCSR_RC_3, `PCSR_RC_1S};
            1: v[i] = c inside {`PCSR_RC_3, `PCSR_RC_4} || (c == `PCSR_RC_1S && !f);
            2: v[i] = (c == `PCSR_RC_2);
            default: v[i] = (c == `PCSR_RC_4);
         endcase
      end
      return v;
   endfunction

   task automatic t_reset(input logic f);
      fuse_debug_pads_off <= f;
      rst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("pad_ie", rv(0, f), pad_ie);
      chk("pad_pu", rv(1, f) | 22'h0c0000, pad_pu);
      chk("pad_pd", rv(2, f), pad_pd);
      chk("pad_oe", rv(3, f), pad_oe);
      apb(1'b0, cfg(6), 32'h0);
      chk("cfg6", f ? 32'h5 : 32'hd, rd & 32'h1f);
      apb(1'b0, cfg(9), 32'h0);
      chk("cfg9", 32'hd, rd & 32'h1f);
   endtask

   task automatic t_usb;
      usb_dplus_pullup_ctl <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("usb pu off", 2'b00, pad_pu[19:18]);
      wr(cfg(18), 32'h9);
      chk("usb pu own", 2'b01, pad_pu[19:18]);
      usb_dplus_pullup_ctl <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("usb pu both", 2'b11, pad_pu[19:18]);
   endtask

   task automatic t_func;
      fn0_out[3] <= 1'b1;
      fn0_oe[3]  <= 1'b1;
      fn2_oe[3]  <= 1'b1;
      wr(`PCSR_OFF_DOUT, 32'h8);
      for (int f = 0; f < 4; f++) begin
         wr(cfg(3), 32'(f) | 32'h4);
         chk("fn out oe", {f < 2, f[0] == 1'b0}, {pad_out[3], pad_oe[3]});
      end
      wr(cfg(3), 32'h5);
      wr(`PCSR_OFF_OE, 32'h8);
      chk("gpio drive", 2'b11, {pad_out[3], pad_oe[3]});
   endtask

   task automatic t_route;
      wr(cfg(5), 32'ha1);
      peri_out[2] <= 1'b1;
      peri_oe[2]  <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk("routed out", 2'b11, {pad_out[5], pad_oe[5]});
      wr(`PCSR_OFF_ISEL0 + 12'hc, 32'h9);
      pad_in[9] <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk("routed in", 1'b1, peri_in[3]);
      pad_in[9] <= 1'b0;
      repeat (8) @(posedge clk_sys);
      chk("routed in low", 1'b0, peri_in[3]);
   endtask

   task automatic t_irq;
      wr(`PCSR_OFF_IPOL, 32'h200);
      wr(`PCSR_OFF_IMASK, 32'h200);
      wr(`PCSR_OFF_ISTAT, 32'h3fffff);
      pad_in[9] <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk("irq edge", 1'b1, irq);
      apb(1'b0, `PCSR_OFF_ISTAT, 32'h0);
      chk("istat", 32'h200, rd);
      wr(`PCSR_OFF_ISTAT, 32'h200);
      chk("irq cleared", 1'b0, irq);
      wr(`PCSR_OFF_ITYPE, 32'h200);
      wr(`PCSR_OFF_ISTAT, 32'h200);
      chk("irq level", 1'b1, irq);
      wr(`PCSR_OFF_IMASK, 32'h0);
      chk("irq masked", 1'b0, irq);
      wr(`PCSR_OFF_IN, 32'h3fffff);
      apb(1'b0, `PCSR_OFF_IN, 32'h0);
      chk("in read", 32'h200, rd);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      wr(`PCSR_OFF_ITYPE, 32'h0);
   endtask

   task automatic t_hold;
      wr(`PCSR_OFF_HOLD, 32'h200);
      wr(cfg(9), 32'h15);
      chk("held pulls", 2'b10, {pad_pu[9], pad_pd[9]});
      wr(`PCSR_OFF_HOLD, 32'h0);
      chk("pull down", 2'b01, {pad_pu[9], pad_pd[9]});
      wr(cfg(9), 32'h5);
      chk("no pull", 2'b00, {pad_pu[9], pad_pd[9]});
      // a floating input pad wastes power, so give it a pull again
      wr(cfg(9), 32'hd);
      chk("pull back", 2'b10, {pad_pu[9], pad_pd[9]});
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #500000;
      fails++;
      results();
   end

   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {pad_in, fn0_out, fn0_oe, fn2_out, fn2_oe, peri_out, peri_oe} = '0;
      usb_dplus_pullup_ctl = 1'b1;
      fuse_debug_pads_off = 1'b0;
      t_reset(1'b0);
      t_usb();
      t_func();
      t_route();
      t_irq();
      t_hold();
      t_reset(1'b1);
      results();
   end
endmodule
